// ### dmas_defines.svh
// Purpose: Constants for the multiply-accumulate slice and its register port
// Assumes: Included by bare name wherever an offset or field is needed
// Notes:   Functional notes follow
// Functional notes
// - Multiplier is one 16x16 or two separate 8x8 halves
// - Accumulator is one 32-bit or two separate 16-bit halves
// - Adder/subtracter 32 or 2x16 bits; result registered or direct
// - Input, intermediate and output registers each bypassable
// - Intermediate register between multiplier and accumulator
// - One clock drives every clocked element
// - Clock gate 1 updates elements, 0 keeps contents
// - A and B feed multiplier or adder directly; B defaults zero
// - C and D go straight to adder and default to zero
// - Each input register has its own freeze; 1 keeps contents
// - Upper clear empties A, C and upper multiplier pipeline
// - Lower clear empties B, D, lower pipeline and result pipeline
// - Output is full 32-bit result or two 16-bit half results
// - Each accumulator half has its own freeze input
// - Each accumulator half has its own active-high clear
// - Load select 0 accumulates, 1 loads the C operand
// - Op select 0 adds, 1 subtracts, per half when split; lower select rules the 32-bit word
// - Cascade carry/borrow taken from previous, given to next slice
// - Carry/borrow taken from lower tile, given to higher tile
// - Sign extension taken from previous, given to next slice
// - Multiply-accumulate at 8x8 and 16x16 widths
`ifndef DMAS_DEFINES_SVH
`define DMAS_DEFINES_SVH

// Register byte offsets
`define DMAS_CTRL_OFF    8'h00
`define DMAS_RESULT_OFF  8'h04
`define DMAS_FLAGS_OFF   8'h08

// Field positions
`define DMAS_CTRL_SWFRZ  0
`define DMAS_FLAG_CARRY  0
`define DMAS_FLAG_SIGN   1

// Reset values
`define DMAS_CTRL_RST    1'h0
`define DMAS_OPND_RST    16'h0000
`define DMAS_WORD_RST    32'h0000_0000

// Operand slots in the input register array
`define DMAS_SLOT_A      0
`define DMAS_SLOT_B      1
`define DMAS_SLOT_C      2
`define DMAS_SLOT_D      3

// AHB-Lite codes
`define DMAS_HTRANS_NSEQ 2'h2
`define DMAS_HRESP_OKAY  1'h0

`endif

// ### dmas_pkg.sv
// Purpose: Types shared by the slice core and its register slave
// Assumes: Offsets and reset values live in dmas_defines.svh
// Notes:   Each module keeps its whole state in one packed struct
package dmas_pkg;

  typedef logic [15:0] dmas_half_t;
  typedef logic [31:0] dmas_word_t;

  // Slice datapath state
  typedef struct packed {
    logic [3:0][15:0] opnd;   // A, B, C, D input registers
    dmas_word_t       mid;    // Intermediate product register
    dmas_word_t       mres;   // Multiplier result register
    dmas_word_t       acc;    // Accumulator, upper and lower halves
  } dmas_core_s;

  // Register slave state
  typedef struct packed {
    logic       wr;           // Write data phase pending
    logic [7:0] addr;         // Latched address of the data phase
    logic       swfrz;        // Software freeze of the whole slice
    dmas_word_t rdata;        // Read data for the data phase
  } dmas_bus_s;

endpackage

// ### dmas_regs_if.sv
// Purpose: Carrier between the slice core and its register slave
// Assumes: Both ends on sys_clk
// Notes:   Core drives state, slave drives control
interface dmas_regs_if;
  logic        swfrz;
  logic [31:0] result;
  logic        carry;
  logic        sign;

  modport core (input swfrz, output result, output carry, output sign);
  modport regs (output swfrz, input result, input carry, input sign);
endinterface

// ### dmas_ahb_regs.sv
// Purpose: AHB-Lite slave giving software control and view of the slice
// Assumes: Single word transfers, zero wait states
// Notes:   Read data is captured at the address phase, so it is a flop
`include "dmas_defines.svh"
module dmas_ahb_regs import dmas_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  dmas_regs_if.regs        rif
);

  dmas_bus_s st_ff;
  dmas_bus_s nxt_st;
  logic      take;

  // Word offset decode shared by reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Only NONSEQ is honoured; size is always a word here
  assign take = hsel & hready & (htrans == `DMAS_HTRANS_NSEQ);

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.wr = take & hwrite;
    if (take) begin
      nxt_st.addr = haddr[7:0];
    end
    // Write lands in the data phase when hwdata is valid
    if (st_ff.wr && hit(st_ff.addr, `DMAS_CTRL_OFF)) begin
      nxt_st.swfrz = hwdata[`DMAS_CTRL_SWFRZ];
    end
    // Unmapped reads return zero
    if (take && !hwrite) begin
      nxt_st.rdata = `DMAS_WORD_RST;
      if (hit(haddr[7:0], `DMAS_CTRL_OFF)) begin
        nxt_st.rdata[`DMAS_CTRL_SWFRZ] = st_ff.swfrz;
      end else if (hit(haddr[7:0], `DMAS_RESULT_OFF)) begin
        nxt_st.rdata = rif.result;
      end else if (hit(haddr[7:0], `DMAS_FLAGS_OFF)) begin
        nxt_st.rdata[`DMAS_FLAG_CARRY] = rif.carry;
        nxt_st.rdata[`DMAS_FLAG_SIGN]  = rif.sign;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '{wr: 1'b0, addr: 8'h00, swfrz: `DMAS_CTRL_RST,
                 rdata: `DMAS_WORD_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = `DMAS_HRESP_OKAY;
  assign hrdata    = st_ff.rdata;
  assign rif.swfrz = st_ff.swfrz;

endmodule

// ### dmas_slice.sv
// Purpose: Multiply-accumulate slice with bypassable pipeline registers
// Assumes: Fabric controls are on sys_clk; modes fixed at build time
// Notes:   Carry and sign outputs are combinational, as in a carry chain
`include "dmas_defines.svh"
module dmas_slice import dmas_pkg::*; #(
  parameter bit [3:0] IN_REG     = 4'hf, // Per operand A,B,C,D register
  parameter bit       MID_REG    = 1'b1, // Intermediate product register
  parameter bit       MRES_REG   = 1'b1, // Multiplier result register
  parameter bit       OUT_REG    = 1'b1, // 1 accumulator, 0 direct sum
  parameter bit       SPLIT_MULT = 1'b0, // 1 two 8x8, 0 one 16x16
  parameter bit       SPLIT_ACC  = 1'b0, // 1 two 16-bit, 0 one 32-bit
  parameter bit       USE_MULT   = 1'b1, // 0 A and B go straight to adder
  parameter bit       ACC_FB     = 1'b1, // 1 add to accumulator, 0 to C:D
  parameter bit       CHAIN_CIN  = 1'b0, // 1 carry from slice, 0 from tile
  parameter bit       SIGN_FILL  = 1'b0  // 1 addend is chain sign fill
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        slice_clock_gate,
  input  wire logic [15:0] op_a,
  input  wire logic [15:0] op_b = 16'h0000,
  input  wire logic [15:0] op_c = 16'h0000,
  input  wire logic [15:0] op_d = 16'h0000,
  input  wire logic        operand_a_freeze_port,
  input  wire logic        operand_b_freeze_port,
  input  wire logic        operand_c_freeze_port,
  input  wire logic        operand_d_freeze_port,
  input  wire logic        upper_input_clear_port,
  input  wire logic        lower_input_clear_port,
  input  wire logic        upper_acc_freeze_port,
  input  wire logic        upper_acc_clear_port,
  input  wire logic        upper_acc_load_port,
  input  wire logic        upper_acc_op_port,
  input  wire logic        lower_acc_freeze_port,
  input  wire logic        lower_acc_clear_port,
  input  wire logic        lower_acc_load_port,
  input  wire logic        lower_acc_op_port,
  input  wire logic        chain_carry_in_port,
  input  wire logic        tile_carry_in,
  input  wire logic        chain_sign_in,
  output logic [31:0]      result_out,
  output logic             chain_carry_out_port,
  output logic             tile_carry_out,
  output logic             chain_sign_out,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);

  dmas_core_s       st_ff;
  dmas_core_s       nxt_st;
  dmas_regs_if      rif();
  logic             gate;
  logic [3:0]       freeze;
  logic [3:0][15:0] opnd_in;
  logic [3:0][15:0] opnd_sel;
  dmas_word_t       prod;
  dmas_word_t       mid_sel;
  dmas_word_t       mult_out;
  dmas_word_t       addend;
  dmas_word_t       augend;
  logic             cin;
  logic             c0_lo;
  logic             c0_hi;
  logic             op_hi;
  dmas_half_t       add_lo;
  dmas_half_t       add_hi;
  logic [16:0]      sum_lo;
  logic [16:0]      sum_hi;
  dmas_word_t       sum;

  // Unsigned 8x8 product, one per half in split mode
  function automatic dmas_half_t umul8(input logic [7:0] x,
                                       input logic [7:0] y);
    umul8 = 16'(x) * 16'(y);
  endfunction

  // Software freeze lets the bus stop the slice like the fabric gate
  assign gate = slice_clock_gate & ~rif.swfrz;

  assign opnd_in = {op_d, op_c, op_b, op_a};
  assign freeze  = {operand_d_freeze_port, operand_c_freeze_port,
                    operand_b_freeze_port, operand_a_freeze_port};

  // Per operand bypass of the input registers
  for (genvar i = 0; i < 4; i++) begin : g_opnd
    assign opnd_sel[i] = IN_REG[i] ? st_ff.opnd[i] : opnd_in[i];
  end

  // Multiplier: full width or two isolated byte halves
  always_comb begin
    if (SPLIT_MULT) begin
      prod = {umul8(opnd_sel[`DMAS_SLOT_A][15:8],
                    opnd_sel[`DMAS_SLOT_B][15:8]),
              umul8(opnd_sel[`DMAS_SLOT_A][7:0],
                    opnd_sel[`DMAS_SLOT_B][7:0])};
    end else begin
      prod = 32'(opnd_sel[`DMAS_SLOT_A]) * 32'(opnd_sel[`DMAS_SLOT_B]);
    end
  end

  // Two optional pipeline stages behind the multiplier
  assign mid_sel  = MID_REG ? st_ff.mid : prod;
  assign mult_out = MRES_REG ? st_ff.mres : mid_sel;

  // Addend: product, raw A:B, or the sign fill of a lower slice
  always_comb begin
    if (SIGN_FILL) begin
      addend = {32{chain_sign_in}};
    end else if (USE_MULT) begin
      addend = mult_out;
    end else begin
      addend = {opnd_sel[`DMAS_SLOT_A], opnd_sel[`DMAS_SLOT_B]};
    end
  end

  // Augend: running accumulator for MAC, else the C:D operands
  assign augend = ACC_FB ? st_ff.acc
                : {opnd_sel[`DMAS_SLOT_C], opnd_sel[`DMAS_SLOT_D]};

  // Carry-in means borrow when subtracting, so it is inverted then
  assign cin   = CHAIN_CIN ? chain_carry_in_port : tile_carry_in;
  assign c0_lo = lower_acc_op_port ? ~cin : cin;
  // Whole-word mode uses one operation so the carry stays meaningful
  assign op_hi = SPLIT_ACC ? upper_acc_op_port : lower_acc_op_port;

  // Invert at 16 bits before widening, so bit 16 keeps a true carry
  assign add_lo = lower_acc_op_port ? ~addend[15:0] : addend[15:0];
  assign add_hi = op_hi ? ~addend[31:16] : addend[31:16];

  // Lower half adder/subtracter
  always_comb begin
    sum_lo = 17'(augend[15:0])
           + 17'(add_lo)
           + 17'(c0_lo);
  end

  // Upper half: chained in 32-bit mode, isolated when split
  assign c0_hi = SPLIT_ACC ? op_hi : sum_lo[16];

  always_comb begin
    sum_hi = 17'(augend[31:16])
           + 17'(add_hi)
           + 17'(c0_hi);
  end

  assign sum = {sum_hi[15:0], sum_lo[15:0]};

  // Next state: input registers, product pipeline, accumulator
  always_comb begin
    nxt_st = st_ff;
    if (gate) begin
      for (int i = 0; i < 4; i++) begin
        if ((i == `DMAS_SLOT_A || i == `DMAS_SLOT_C) &&
            upper_input_clear_port) begin
          nxt_st.opnd[i] = `DMAS_OPND_RST;
        end else if ((i == `DMAS_SLOT_B || i == `DMAS_SLOT_D) &&
                     lower_input_clear_port) begin
          nxt_st.opnd[i] = `DMAS_OPND_RST;
        end else if (!freeze[i]) begin
          nxt_st.opnd[i] = opnd_in[i];
        end
      end
      // Intermediate product halves follow their own clears
      nxt_st.mid[31:16] = upper_input_clear_port ? `DMAS_OPND_RST
                        : prod[31:16];
      nxt_st.mid[15:0]  = lower_input_clear_port ? `DMAS_OPND_RST
                        : prod[15:0];
      nxt_st.mres       = lower_input_clear_port ? `DMAS_WORD_RST
                        : mid_sel;
      // Upper accumulator half
      if (upper_acc_clear_port) begin
        nxt_st.acc[31:16] = `DMAS_OPND_RST;
      end else if (!upper_acc_freeze_port) begin
        nxt_st.acc[31:16] = upper_acc_load_port ? opnd_sel[`DMAS_SLOT_C]
                          : sum[31:16];
      end
      // Lower accumulator half
      if (lower_acc_clear_port) begin
        nxt_st.acc[15:0] = `DMAS_OPND_RST;
      end else if (!lower_acc_freeze_port) begin
        nxt_st.acc[15:0] = lower_acc_load_port ? opnd_sel[`DMAS_SLOT_C]
                         : sum[15:0];
      end
    end
  end

  // Every element on the one slice clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '{opnd: '0, mid: `DMAS_WORD_RST, mres: `DMAS_WORD_RST,
                 acc: `DMAS_WORD_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Result: accumulator flop, or the adder straight through
  assign result_out = OUT_REG ? st_ff.acc : sum;

  // Carry/borrow out of the top half goes to both neighbours
  assign chain_carry_out_port = op_hi ? ~sum_hi[16] : sum_hi[16];
  assign tile_carry_out       = chain_carry_out_port;
  assign chain_sign_out       = addend[31];

  assign rif.result = result_out;
  assign rif.carry  = chain_carry_out_port;
  assign rif.sign   = chain_sign_out;

  dmas_ahb_regs u_regs (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .rif       (rif)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // A closed gate freezes the accumulator and the operands
  gate_hold_a: assert property (
    !gate |=> $stable(st_ff.acc) && $stable(st_ff.opnd))
    else $error("slice state moved with gate low");

  // Frozen operand keeps its value
  opnd_freeze_a: assert property (
    gate && !upper_input_clear_port && operand_a_freeze_port
    |=> st_ff.opnd[`DMAS_SLOT_A] == $past(st_ff.opnd[`DMAS_SLOT_A]))
    else $error("frozen operand A changed");

  // Free operand follows its input
  opnd_load_a: assert property (
    gate && !lower_input_clear_port && !operand_d_freeze_port
    |=> st_ff.opnd[`DMAS_SLOT_D] == $past(op_d))
    else $error("operand D failed to load");

  upper_clear_a: assert property (
    gate && upper_input_clear_port
    |=> st_ff.opnd[`DMAS_SLOT_A] == 16'h0000 &&
        st_ff.opnd[`DMAS_SLOT_C] == 16'h0000 &&
        st_ff.mid[31:16] == 16'h0000)
    else $error("upper clear left data");

  lower_clear_a: assert property (
    gate && lower_input_clear_port
    |=> st_ff.opnd[`DMAS_SLOT_B] == 16'h0000 &&
        st_ff.mres == 32'h0000_0000 && st_ff.mid[15:0] == 16'h0000)
    else $error("lower clear left data");

  acc_clear_a: assert property (
    gate && upper_acc_clear_port |=> st_ff.acc[31:16] == 16'h0000)
    else $error("upper accumulator not cleared");

  acc_freeze_a: assert property (
    gate && !lower_acc_clear_port && lower_acc_freeze_port
    |=> $stable(st_ff.acc[15:0]))
    else $error("frozen lower accumulator changed");

  acc_load_a: assert property (
    gate && !lower_acc_clear_port && !lower_acc_freeze_port &&
    lower_acc_load_port
    |=> st_ff.acc[15:0] == $past(opnd_sel[`DMAS_SLOT_C]))
    else $error("lower accumulator missed C load");

  acc_add_a: assert property (
    gate && !lower_acc_clear_port && !lower_acc_freeze_port &&
    !lower_acc_load_port && !lower_acc_op_port
    |=> st_ff.acc[15:0] == 16'($past(augend[15:0]) + $past(addend[15:0])
                               + 16'($past(cin))))
    else $error("lower accumulator add wrong");

  // Second register of each clear group: freeze and load
  opnd_b_freeze_a: assert property (
    gate && !lower_input_clear_port && operand_b_freeze_port
    |=> $stable(st_ff.opnd[`DMAS_SLOT_B]))
    else $error("frozen operand B changed");

  opnd_c_load_a: assert property (
    gate && !upper_input_clear_port && !operand_c_freeze_port
    |=> st_ff.opnd[`DMAS_SLOT_C] == $past(op_c))
    else $error("operand C failed to load");

  // Product pipeline advances one stage per gated edge
  mid_load_a: assert property (
    gate && !upper_input_clear_port && !lower_input_clear_port
    |=> st_ff.mid == $past(prod))
    else $error("mid register missed product");

  mres_load_a: assert property (
    gate && !lower_input_clear_port |=> st_ff.mres == $past(mid_sel))
    else $error("result register missed product");

  lower_acc_clear_a: assert property (
    gate && lower_acc_clear_port |=> st_ff.acc[15:0] == 16'h0000)
    else $error("lower accumulator not cleared");

  upper_freeze_a: assert property (
    gate && !upper_acc_clear_port && upper_acc_freeze_port
    |=> $stable(st_ff.acc[31:16]))
    else $error("frozen upper accumulator changed");

  upper_load_a: assert property (
    gate && !upper_acc_clear_port && !upper_acc_freeze_port &&
    upper_acc_load_port
    |=> st_ff.acc[31:16] == $past(opnd_sel[`DMAS_SLOT_C]))
    else $error("upper accumulator missed C load");

  acc_sub_a: assert property (
    gate && !lower_acc_clear_port && !lower_acc_freeze_port &&
    !lower_acc_load_port && lower_acc_op_port
    |=> st_ff.acc[15:0] == 16'($past(augend[15:0]) - $past(addend[15:0])
                               - 16'($past(cin))))
    else $error("lower accumulator subtract wrong");

  // Whole word: the lower carry must ripple into the upper half
  word_chain_a: assert property (
    !SPLIT_ACC && gate && !upper_acc_clear_port && !lower_acc_clear_port &&
    !upper_acc_freeze_port && !lower_acc_freeze_port &&
    !upper_acc_load_port && !lower_acc_load_port
    |=> st_ff.acc == ($past(lower_acc_op_port)
                      ? $past(augend) - $past(addend) - 32'($past(cin))
                      : $past(augend) + $past(addend) + 32'($past(cin))))
    else $error("whole-word accumulate lost the carry");

  // Split halves: the upper sum takes no carry from below
  split_upper_a: assert property (
    SPLIT_ACC && gate && !upper_acc_clear_port && !upper_acc_freeze_port &&
    !upper_acc_load_port
    |=> st_ff.acc[31:16] == 16'($past(upper_acc_op_port)
          ? $past(augend[31:16]) - $past(addend[31:16])
          : $past(augend[31:16]) + $past(addend[31:16])))
    else $error("split upper half took a carry");

endmodule

// ### dmas_fabric_model.sv
// Purpose: Fabric-side model driving the slice operands and controls
// Assumes: Changes only just after a rising sys_clk edge
// Notes:   Controls are sparse so that long accumulations build up
module dmas_fabric_model (
  input  wire logic        sys_clk,
  output logic      [63:0] ops,
  output logic      [17:0] ctl
);
  timeunit 1ns;
  timeprecision 1ps;

  int seed = 92;

  // Quiet start: slice enabled, every operand zero
  initial begin
    ops = 64'h0;
    ctl = 18'h00001;
  end

  // One fixed vector for a directed step
  task automatic put(input logic [63:0] o, input logic [17:0] c);
    ops <= o;
    ctl <= c;
  endtask

  // Random step; all-ones operand often, to reach the carry boundary
  task automatic rnd();
    logic [63:0] o;
    logic [17:0] c;
    o = {$random(seed), $random(seed)};
    if ($unsigned($random(seed)) % 4 == 0) o[15:0] = 16'hffff;
    for (int i = 1; i < 15; i++) c[i] = ($unsigned($random(seed)) % 9 == 0);
    c[0] = ($unsigned($random(seed)) % 8 != 0);
    c[17:15] = 3'($random(seed));
    ops <= o;
    ctl <= c;
  endtask
endmodule

// ### test_dsp_multiply_accumulate_slice.sv
// Purpose: Self-checking bench comparing the slice with a cycle model
// Assumes: Default build: all stages registered, 16x16, 32-bit, tile carry
// Notes:   Control map in ctl: 0 gate, 1-4 freezes, 5-6 input clears,
//          7-10 upper acc freeze/clear/load/op, 11-14 the same for lower
module test_dsp_multiply_accumulate_slice import dmas_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk, rst, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, result_out, split_res;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        tile_co, chain_co, sign_o;
  logic [63:0] ops;
  logic [17:0] ctl;
  int          n_errors, check_count;
  logic [15:0] m_op [4];
  dmas_word_t  m_mid, m_mres, m_acc, m_prod, flags;
  logic [32:0] m_sum, m_chk;
  logic        m_sw, m_wpend, m_gate;
  logic [7:0]  m_wa;

  dmas_fabric_model fab (.sys_clk(sys_clk), .ops(ops), .ctl(ctl));

  dmas_slice DUT (
    .sys_clk(sys_clk), .rst(rst), .slice_clock_gate(ctl[0]),
    .op_a(ops[15:0]), .op_b(ops[31:16]),
    .op_c(ops[47:32]), .op_d(ops[63:48]),
    .operand_a_freeze_port(ctl[1]), .operand_b_freeze_port(ctl[2]),
    .operand_c_freeze_port(ctl[3]), .operand_d_freeze_port(ctl[4]),
    .upper_input_clear_port(ctl[5]), .lower_input_clear_port(ctl[6]),
    .upper_acc_freeze_port(ctl[7]), .upper_acc_clear_port(ctl[8]),
    .upper_acc_load_port(ctl[9]), .upper_acc_op_port(ctl[10]),
    .lower_acc_freeze_port(ctl[11]), .lower_acc_clear_port(ctl[12]),
    .lower_acc_load_port(ctl[13]), .lower_acc_op_port(ctl[14]),
    .chain_carry_in_port(ctl[15]), .tile_carry_in(ctl[16]),
    .chain_sign_in(ctl[17]), .result_out(result_out),
    .chain_carry_out_port(chain_co), .tile_carry_out(tile_co),
    .chain_sign_out(sign_o), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp)
  );

  // Split build, every stage bypassed, C:D as augend: pure combinational
  dmas_slice #(.IN_REG(4'h0), .MID_REG(1'b0), .MRES_REG(1'b0),
    .OUT_REG(1'b0), .SPLIT_MULT(1'b1), .SPLIT_ACC(1'b1), .ACC_FB(1'b0))
  DUT_SPLIT (
    .sys_clk(sys_clk), .rst(rst), .slice_clock_gate(ctl[0]),
    .op_a(ops[15:0]), .op_b(ops[31:16]),
    .op_c(ops[47:32]), .op_d(ops[63:48]),
    .operand_a_freeze_port(ctl[1]), .operand_b_freeze_port(ctl[2]),
    .operand_c_freeze_port(ctl[3]), .operand_d_freeze_port(ctl[4]),
    .upper_input_clear_port(ctl[5]), .lower_input_clear_port(ctl[6]),
    .upper_acc_freeze_port(ctl[7]), .upper_acc_clear_port(ctl[8]),
    .upper_acc_load_port(ctl[9]), .upper_acc_op_port(ctl[10]),
    .lower_acc_freeze_port(ctl[11]), .lower_acc_clear_port(ctl[12]),
    .lower_acc_load_port(ctl[13]), .lower_acc_op_port(ctl[14]),
    .chain_carry_in_port(ctl[15]), .tile_carry_in(ctl[16]),
    .chain_sign_in(ctl[17]), .result_out(split_res),
    .chain_carry_out_port(), .tile_carry_out(), .chain_sign_out(),
    .hsel(1'b0), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(1'b1), .hreadyout(),
    .hrdata(), .hresp()
  );

  // Two isolated halves: byte products into C and D, upper gets no carry
  function automatic logic [31:0] split_exp();
    logic [15:0] p_lo, p_hi, e_lo, e_hi;
    p_lo = 16'(ops[7:0]) * 16'(ops[23:16]);
    p_hi = 16'(ops[15:8]) * 16'(ops[31:24]);
    e_lo = ctl[14] ? ops[63:48] - p_lo - 16'(ctl[16])
                   : ops[63:48] + p_lo + 16'(ctl[16]);
    e_hi = ctl[10] ? ops[47:32] - p_hi : ops[47:32] + p_hi;
    return {e_hi, e_lo};
  endfunction

  // Free-running 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Adder seen by the accumulator; lower op select rules the whole word
  function automatic logic [32:0] sum33();
    if (ctl[14]) return {1'b0, m_acc} - {1'b0, m_mres} - 33'(ctl[16]);
    return {1'b0, m_acc} + {1'b0, m_mres} + 33'(ctl[16]);
  endfunction

  // Cycle model; old values are read first, so stages update last-to-first
  always @(posedge sys_clk) begin
    m_gate = ctl[0] & ~m_sw;
    m_sum = sum33();
    m_prod = 32'(m_op[0]) * 32'(m_op[1]);
    if (rst) begin
      m_op = '{default: 16'h0};
      {m_mid, m_mres, m_acc, m_sw, m_wpend} = '0;
    end else begin
      if (m_wpend && m_wa == 8'h00) m_sw = hwdata[0];
      m_wpend = hsel & hready & (htrans == 2'h2) & hwrite;
      m_wa = haddr[7:0];
      if (m_gate) begin
        m_acc[31:16] = ctl[8] ? 16'h0 : ctl[7] ? m_acc[31:16] :
                       ctl[9] ? m_op[2] : m_sum[31:16];
        m_acc[15:0] = ctl[12] ? 16'h0 : ctl[11] ? m_acc[15:0] :
                      ctl[13] ? m_op[2] : m_sum[15:0];
        m_mres = ctl[6] ? 32'h0 : m_mid;
        m_mid = {ctl[5] ? 16'h0 : m_prod[31:16],
                 ctl[6] ? 16'h0 : m_prod[15:0]};
        for (int i = 0; i < 4; i++)
          if (i[0] ? ctl[6] : ctl[5]) m_op[i] = 16'h0;
          else if (!ctl[1 + i]) m_op[i] = ops[16 * i +: 16];
      end
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Outputs are settled mid-cycle; carry out reads as borrow on subtract
  always @(negedge sys_clk) begin
    if (!rst) begin
      m_chk = sum33();
      cmp(result_out, m_acc);
      cmp_bit(sign_o, m_mres[31]);
      cmp_bit(tile_co, m_chk[32]);
      cmp_bit(chain_co, m_chk[32]);
      cmp(split_res, split_exp());
    end
  end

  // One single-word transfer; read data taken at the data-phase edge
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, input logic [31:0] exp);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsel <= 1'b1;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    if (!wr) cmp(hrdata, exp);
    cmp_bit(hresp, 1'b0);
  endtask

  task automatic test_done();
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Cut a hang short; the whole run needs under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    test_done();
  end

  initial begin
    {rst, hsel, hwrite, hwdata, haddr, htrans} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    n_errors = 0;
    check_count = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    // Walk 3 x 5 through every stage into the accumulator
    fab.put({16'h0, 16'h0, 16'h5, 16'h3}, 18'h00001);
    repeat (6) @(posedge sys_clk);
    repeat (400) begin
      fab.rnd();
      @(posedge sys_clk);
    end
    // Reset in mid-run, then random traffic again
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (200) begin
      fab.rnd();
      @(posedge sys_clk);
    end
    // Software freeze holds an accumulation in progress
    fab.put({16'h0, 16'h1234, 16'h7, 16'hff09}, 18'h10001);
    repeat (6) @(posedge sys_clk);
    ahb(1'b1, 8'h00, 32'h1, 32'h0);
    repeat (5) @(posedge sys_clk);
    flags = {30'h0, m_mres[31], 1'(sum33() >> 32)};
    ahb(1'b0, 8'h00, 32'h0, 32'h1);
    ahb(1'b0, 8'h04, 32'h0, m_acc);
    ahb(1'b0, 8'h08, 32'h0, flags);
    ahb(1'b1, 8'h04, 32'hffff_ffff, 32'h0);
    ahb(1'b0, 8'h04, 32'h0, m_acc);
    ahb(1'b0, 8'h0c, 32'h0, 32'h0);
    ahb(1'b1, 8'h00, 32'h0, 32'h0);
    repeat (8) @(posedge sys_clk);
    test_done();
  end
endmodule
